// ==== dcpm_ctrl.sv ====
// Clock source selection and operating mode sequencer with Wishbone registers.
// Assumes wake sources are synchronous single-cycle or level events from core logic.
`timescale 1ns/1ps
module dcpm_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wake events
  input wire dcpm_pkg::dcpm_wake_t wake_i,
  // Clock gating and status
  output dcpm_pkg::dcpm_gate_t gate_o,
  output logic inst_tick_o,
  output logic wdt_clear_o,
  output logic powerdown_flag_o,
  output logic timeout_flag_o,
  output logic wake_vector_o,
  output logic [11:0] resume_addr_o,
  output logic [2:0] mode_o
);
  import dcpm_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] osc_r;
  logic [7:0] osc_nxt;
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  dcpm_state_t state_r;
  dcpm_state_t state_nxt;
  logic [4:0] settle_r;
  logic [4:0] settle_nxt;
  logic [1:0] div_r;
  logic global_irq_enable_r;
  logic start_done_r;
  logic powerdown_flag_r;
  logic timeout_flag_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  dcpm_gate_t gate_r;
  dcpm_gate_t gate_nxt;
  logic tick_r;
  logic wdt_clr_r;
  logic vec_r;
  logic vec_nxt;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
  wire wr_osc = wr_lane0 && (wb_adr_i == DCPM_ADDR_OSC_MODE);
  wire wr_cfg = wr_lane0 && (wb_adr_i == DCPM_ADDR_CONFIG);
  wire wr_core = wr_lane0 && (wb_adr_i == DCPM_ADDR_CORE);
  wire sleep_instr = wr_core && wb_dat_i[0];
  wire irq_enable_instr = wr_core && wb_dat_i[1];
  wire irq_disable_instr = wr_core && wb_dat_i[2];
  wire [7:0] wdat = wb_dat_i[7:0];
  wire [1:0] pm_wr = wdat[DCPM_PM_LO+1:DCPM_PM_LO];
  wire [2:0] freq_wr = (wdat[2:0] > DCPM_FREQ_MAX) ? DCPM_FREQ_MAX : wdat[2:0];
  wire high_clock_select = osc_r[DCPM_SEL_BIT];
  wire high_osc_stop = osc_r[DCPM_STOP_BIT];

  // ----------------------------------------
  // Wake decode
  // ----------------------------------------
  wire wake_stby = wake_i.timer0_ovf || wake_i.timer1_unf || wake_i.wdt_timeout
                   || wake_i.port_b_change || wake_i.ext_pin
                   || wake_i.low_voltage_detect;
  wire wake_halt = wake_i.wdt_timeout || wake_i.port_b_change || wake_i.ext_pin;
  wire run_state = (state_r == DCPM_SLOW) || (state_r == DCPM_NORMAL);
  wire go_halt = run_state && (sleep_instr || (wr_osc && pm_wr == DCPM_PM_HALT));
  wire go_stby = run_state && wr_osc && (pm_wr == DCPM_PM_STBY);
  wire [7:0] osc_wr_val = {wdat[7:4], DCPM_PM_RUN, wdat[1:0]};

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    osc_nxt = osc_r;
    vec_nxt = 1'b0;
    if (wr_osc) begin
      // Stop and select land together; pairing them is legal for Halt entry
      osc_nxt = {osc_wr_val[7:4], pm_wr, osc_wr_val[1:0]};
    end
    if (sleep_instr) begin
      osc_nxt[DCPM_PM_LO+1:DCPM_PM_LO] = DCPM_PM_HALT;
    end
    unique case (state_r)
      DCPM_NORMAL, DCPM_SLOW: begin
        if (go_halt) begin
          state_nxt = DCPM_HALT;
        end else if (go_stby) begin
          state_nxt = DCPM_STANDBY;
        end else begin
          state_nxt = osc_nxt[DCPM_SEL_BIT] ? DCPM_NORMAL : DCPM_SLOW;
        end
      end
      DCPM_STANDBY: begin
        if (wake_stby) begin
          state_nxt = high_clock_select ? DCPM_NORMAL : DCPM_SLOW;
          osc_nxt[DCPM_PM_LO+1:DCPM_PM_LO] = DCPM_PM_RUN;
          vec_nxt = global_irq_enable_r;
        end
      end
      DCPM_HALT: begin
        if (wake_halt) begin
          state_nxt = DCPM_SETTLE;
          settle_nxt = DCPM_SETTLE_CNT - 5'h1;
          osc_nxt[DCPM_PM_LO+1:DCPM_PM_LO] = DCPM_PM_RUN;
        end
      end
      DCPM_SETTLE: begin
        // Slow oscillator restarts here, fast one too unless its stop bit is set; execution still held
        if (settle_r == 5'h0) begin
          state_nxt = high_clock_select ? DCPM_NORMAL : DCPM_SLOW;
          vec_nxt = global_irq_enable_r;
        end else begin
          settle_nxt = settle_r - 5'h1;
        end
      end
      default: begin
        state_nxt = DCPM_NORMAL;
      end
    endcase
  end

  // ----------------------------------------
  // Gating outputs
  // ----------------------------------------
  wire halted = (state_r == DCPM_HALT);
  wire settling = (state_r == DCPM_SETTLE);
  wire normal_st = (state_r == DCPM_NORMAL);
  wire running = run_state;
  always_comb begin
    gate_nxt.fast_rc_osc_en = !halted && !high_osc_stop;
    gate_nxt.slow_rc_osc_en = !halted;
    gate_nxt.sys_clk_fast = high_clock_select;
    gate_nxt.exec_en = running;
    gate_nxt.timers_en = !halted && !settling;
    gate_nxt.periph_en = running;
    gate_nxt.timer0_slow = normal_st && osc_r[DCPM_T0SLOW_BIT]
                           && cfg_r[DCPM_CFG_T0SRC];
  end

  // Instruction tick counts system clock edges; limits: one bus clock stands for a period
  wire div4 = cfg_r[DCPM_CFG_DIV4];
  wire tick_now = div4 ? (div_r == 2'h3) : div_r[0];

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] status_val = {2'h0, state_r, timeout_flag_r, powerdown_flag_r, global_irq_enable_r};
  always_comb begin
    dat_nxt = 32'h0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        DCPM_ADDR_OSC_MODE: dat_nxt = {24'h0, osc_r};
        DCPM_ADDR_CONFIG: dat_nxt = {24'h0, cfg_r};
        DCPM_ADDR_STATUS: dat_nxt = {24'h0, status_val};
        default: dat_nxt = 32'h0;
      endcase
    end
  end

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = {wdat[7:3], freq_wr};
    end
  end

  // ----------------------------------------
  // Startup
  // ----------------------------------------
  // Startup choice taken one edge after reset release; the bus still answers, but osc_r and cfg_r writes are dropped until then
  wire start_pending = !start_done_r;
  wire start_fast = cfg_r[DCPM_CFG_STARTFAST];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_done_r <= 1'b0;
    end else begin
      start_done_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Mode and register state
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_r <= DCPM_OSC_RESET;
    end else if (start_pending) begin
      osc_r[DCPM_SEL_BIT] <= start_fast;
    end else begin
      osc_r <= osc_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= DCPM_CFG_RESET;
    end else if (!start_pending) begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= DCPM_NORMAL;
    end else if (start_pending) begin
      state_r <= start_fast ? DCPM_NORMAL : DCPM_SLOW;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_r <= 5'h0;
    end else if (!start_pending) begin
      settle_r <= settle_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable_r <= 1'b0;
    end else if (irq_enable_instr) begin
      global_irq_enable_r <= 1'b1;
    end else if (irq_disable_instr) begin
      global_irq_enable_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // No watchdog timeout feeds it, so the timeout flag is set by reset and sleep and never clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      powerdown_flag_r <= 1'b1;
      timeout_flag_r <= 1'b1;
    end else if (go_halt) begin
      powerdown_flag_r <= 1'b0;
      timeout_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_clr_r <= 1'b0;
    end else begin
      wdt_clr_r <= go_halt;
    end
  end

  // ----------------------------------------
  // Instruction clock
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      // Held at zero while asleep so the first tick after wake is a full period
      div_r <= running ? div_r + 2'h1 : 2'h0;
      tick_r <= running && tick_now;
    end
  end

  // ----------------------------------------
  // Gates and wake vector
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_r <= 1'b0;
      gate_r <= '0;
    end else begin
      vec_r <= vec_nxt;
      gate_r <= gate_nxt;
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req;
      dat_r <= dat_nxt;
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign gate_o = gate_r;
  assign inst_tick_o = tick_r;
  assign wdt_clear_o = wdt_clr_r;
  assign powerdown_flag_o = powerdown_flag_r;
  assign timeout_flag_o = timeout_flag_r;
  assign wake_vector_o = vec_r;
  assign resume_addr_o = DCPM_IRQ_VECTOR;
  assign mode_o = state_r;
endmodule

// ==== dcpm_pkg.sv ====
// Package for the dual clock power mode controller.
// Assumes a Wishbone classic bus with 32-bit data and 8-bit registers in the low bits.
package dcpm_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] DCPM_ADDR_OSC_MODE = 4'h0;
  localparam logic [3:0] DCPM_ADDR_CONFIG = 4'h4;
  localparam logic [3:0] DCPM_ADDR_STATUS = 4'h8;
  localparam logic [3:0] DCPM_ADDR_CORE = 4'hc;
  // Oscillator mode control fields
  localparam int DCPM_SEL_BIT = 0;
  localparam int DCPM_STOP_BIT = 1;
  localparam int DCPM_PM_LO = 2;
  localparam int DCPM_T0SLOW_BIT = 4;
  localparam logic [7:0] DCPM_OSC_RESET = 8'h01;
  // Config fields: [2:0] fast freq, [3] div4, [4] startup fast, [5] timer0 source
  localparam int DCPM_CFG_DIV4 = 3;
  localparam int DCPM_CFG_STARTFAST = 4;
  localparam int DCPM_CFG_T0SRC = 5;
  localparam logic [7:0] DCPM_CFG_RESET = 8'h10;
  // Core control bits: [0] sleep instr, [1] irq enable instr, [2] irq disable instr
  localparam logic [1:0] DCPM_PM_RUN = 2'h0;
  localparam logic [1:0] DCPM_PM_HALT = 2'h1;
  localparam logic [1:0] DCPM_PM_STBY = 2'h2;
  // ----------------------------------------
  // Timing and constants
  // ----------------------------------------
  localparam int DCPM_SETTLE_PERIODS = 16;
  localparam logic [4:0] DCPM_SETTLE_CNT = 5'(DCPM_SETTLE_PERIODS);
  localparam int DCPM_SLOW_HZ = 32768;
  localparam logic [11:0] DCPM_IRQ_VECTOR = 12'h008;
  localparam logic [2:0] DCPM_FREQ_MAX = 3'h5;
  typedef enum logic [2:0] {
    DCPM_NORMAL = 3'b000,
    DCPM_SLOW = 3'b001,
    DCPM_STANDBY = 3'b010,
    DCPM_HALT = 3'b011,
    DCPM_SETTLE = 3'b100
  } dcpm_state_t;
  // Wake sources
  typedef struct packed {
    logic timer0_ovf;
    logic timer1_unf;
    logic wdt_timeout;
    logic port_b_change;
    logic ext_pin;
    logic low_voltage_detect;
  } dcpm_wake_t;
  // Clock and gate outputs
  typedef struct packed {
    logic fast_rc_osc_en;
    logic slow_rc_osc_en;
    logic sys_clk_fast;
    logic exec_en;
    logic timers_en;
    logic periph_en;
    logic timer0_slow;
  } dcpm_gate_t;
endpackage

// ==== dcpm_ctrl_assertions.sv ====
// Port-level checks for the mode controller.
// Assumes one clock with synchronous reset; bound onto dcpm_ctrl.
`timescale 1ns/1ps
module dcpm_ctrl_assertions
  import dcpm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire dcpm_pkg::dcpm_wake_t wake_i,
  input wire dcpm_pkg::dcpm_gate_t gate_o,
  input wire logic wdt_clear_o,
  input wire logic powerdown_flag_o,
  input wire logic timeout_flag_o,
  input wire logic [11:0] resume_addr_o,
  input wire logic [2:0] mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire halt_wake = wake_i.wdt_timeout | wake_i.port_b_change | wake_i.ext_pin;
  logic [5:0] settle_r;
  // Counter, since a 16-cycle repetition is too long to unroll
  always_ff @(posedge clk_i) settle_r <= (rst_i || mode_o != 3'h4) ? 6'h00 : settle_r + 6'h01;
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer missing or too long");
  property p_halt_off; mode_o == 3'h3 |=> !gate_o.fast_rc_osc_en && !gate_o.slow_rc_osc_en
    && !gate_o.periph_en && !gate_o.timers_en; endproperty
  a_halt_off: assert property (p_halt_off) else $error("gate on in halt");
  property p_stop_exec; mode_o inside {3'h2, 3'h3} |=> !gate_o.exec_en; endproperty
  a_stop_exec: assert property (p_stop_exec) else $error("executing while asleep");
  property p_stby_run; mode_o == 3'h2 |=> gate_o.timers_en && gate_o.slow_rc_osc_en; endproperty
  a_stby_run: assert property (p_stby_run) else $error("standby gates wrong");
  property p_clk_sel; mode_o inside {3'h0, 3'h1} |=>
    gate_o.sys_clk_fast == ($past(mode_o) == 3'h0) && gate_o.slow_rc_osc_en; endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
  property p_halt_wake; mode_o == 3'h3 && halt_wake |-> ##[1:2] mode_o == 3'h4; endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt wake missed");
  property p_halt_hold; mode_o == 3'h3 && !halt_wake && !$past(halt_wake) |=> mode_o == 3'h3;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left without cause");
  property p_stby_wake; mode_o == 3'h2 && (|wake_i) |-> ##[1:2] mode_o inside {3'h0, 3'h1};
  endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("standby wake wrong");
  property p_settle; mode_o != 3'h4 && $past(mode_o) == 3'h4 |-> settle_r == 6'h10; endproperty
  a_settle: assert property (p_settle) else $error("settle length wrong");
  property p_halt_flags; $rose(mode_o == 3'h3) |->
    ##[0:1] (wdt_clear_o && !powerdown_flag_o && timeout_flag_o); endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt entry flags wrong");
  property p_vector; resume_addr_o == DCPM_IRQ_VECTOR; endproperty
  a_vector: assert property (p_vector) else $error("resume address wrong");
endmodule
bind dcpm_ctrl dcpm_ctrl_assertions u_dcpm_ctrl_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wake_i(wake_i), .gate_o(gate_o), .wdt_clear_o(wdt_clear_o),
  .powerdown_flag_o(powerdown_flag_o), .timeout_flag_o(timeout_flag_o),
  .resume_addr_o(resume_addr_o), .mode_o(mode_o)
);

// ==== dcpm_wake_model.sv ====
// Wake event sources: each event line copies its request bit, registered one clock later.
// Assumes requests come on the controller clock.
`timescale 1ns/1ps
module dcpm_wake_model
  import dcpm_pkg::*;
(
  // Clock and request
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] req_i,
  // Event lines
  output dcpm_pkg::dcpm_wake_t wake_o
);
  // Events never linger past their request
  always_ff @(posedge clk_i) begin
    wake_o <= rst_i ? '0 : dcpm_wake_t'(req_i);
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the mode controller.
// Assumes the wake model and the checker are compiled before it.
`timescale 1ns/1ps
module testbench;
  import dcpm_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [5:0] req = 6'h00;
  logic ack, tick, pd, to, vec;
  logic [2:0] mode;
  dcpm_wake_t wake;
  dcpm_gate_t gate;
  int n_fail = 0, checked = 0, ticks = 0, vecs = 0, t0;
  dcpm_ctrl u_dcpm_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wake_i(wake), .gate_o(gate), .inst_tick_o(tick), .wdt_clear_o(),
    .powerdown_flag_o(pd), .timeout_flag_o(to), .wake_vector_o(vec),
    .resume_addr_o(), .mode_o(mode));
  dcpm_wake_model u_dcpm_wake_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .wake_o(wake));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ticks <= ticks + (tick === 1'b1);
    vecs <= vecs + (vec === 1'b1);
  end
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 8'h00);
    check(q, e);
  endtask
  // Bounded wait; a mode never reached ends the run
  task automatic wait_mode(input logic [2:0] m);
    int k;
    for (k = 0; k < 40 && mode !== m; k++) cycles(1);
    check(mode, m);
    if (k == 40) report_and_stop();
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i) req <= 6'h01 << i;
    @(posedge clk_i) req <= 6'h00;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    cycles(2);
    check(mode, 3'h0);
    rd(4'h0, 32'h01);
    rd(4'h4, 32'h10);
    wr(4'h8, 8'hff);
    rd(4'h8, 32'h06);
    rd(4'h2, 32'h00);
    wr(4'h0, 8'he1);
    rd(4'h0, 32'he1);
    wr(4'h0, 8'h00);
    wait_mode(3'h1);
    cycles(1);
    check({gate.sys_clk_fast, gate.fast_rc_osc_en}, 2'b01);
    wr(4'h0, 8'h02);
    cycles(2);
    check(gate.fast_rc_osc_en, 1'b0);
    wr(4'h0, 8'h01);
    wait_mode(3'h0);
    cycles(2);
    check({gate.sys_clk_fast, gate.slow_rc_osc_en}, 2'b11);
    t0 = ticks;
    cycles(8);
    check(ticks - t0, 4);
    wr(4'h4, 8'h18);
    cycles(4);
    t0 = ticks;
    cycles(8);
    check(ticks - t0, 2);
    wr(4'h4, 8'h37);
    rd(4'h4, 32'h35);
    wr(4'h0, 8'h11);
    cycles(2);
    check(gate.timer0_slow, 1'b1);
    wr(4'h0, 8'h01);
    cycles(2);
    check(gate.timer0_slow, 1'b0);
    wr(4'hc, 8'h02);
    rd(4'h8, 32'h07);
    for (int i = 0; i < 6; i++) begin
      wr(4'h0, 8'h09);
      wait_mode(3'h2);
      cycles(1);
      check({gate.exec_en, gate.timers_en}, 2'b01);
      t0 = vecs;
      pulse(i);
      wait_mode(3'h0);
      cycles(2);
      check(vecs - t0, 1);
      rd(4'h0, 32'h01);
    end
    wr(4'h0, 8'h07);
    wait_mode(3'h3);
    cycles(2);
    check({gate.fast_rc_osc_en, gate.slow_rc_osc_en, gate.exec_en, gate.periph_en}, 0);
    check({pd, to}, 2'b01);
    pulse(5);
    cycles(4);
    check(mode, 3'h3);
    t0 = vecs;
    pulse(1);
    wait_mode(3'h4);
    wait_mode(3'h0);
    wr(4'hc, 8'h04);
    wr(4'h0, 8'h00);
    wait_mode(3'h1);
    wr(4'hc, 8'h01);
    wait_mode(3'h3);
    pulse(3);
    wait_mode(3'h1);
    cycles(2);
    check(vecs - t0, 1);
    report_and_stop();
  end
endmodule
